// *** src/rhp_ref_home.sv ***
// Reference switch latching, home capture and position zero/wrap control.
// Assumes synchronous switch inputs and a ramp generator issuing steps.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Right stop turning inactive copies position into latched position if enabled.
// - Right stop turning active copies position into latched position if enabled.
// - Left stop also acts as home when its home bit is set.
// - Right stop also acts as home when its home bit is set.
// - Source zero takes the next encoder index pulse as home event.
// - Sources 6 and 9 put home mid-range, high or low active.
// - Sources 11 and 13 are low active, home at rising or falling edge.
// - Sources 3 and 12 report the inactive level as negative region.
// - Armed tracking stores position as home and raises the done event.
// - Clearing the done event after a capture disarms tracking by itself.
// - Without zeroing, positioning mode holds motion at the target.
// - With zeroing, position clears at target and the next ramp starts.
// - Wraparound confines position to minus range up to range minus one.
// - Each stop polarity bit picks low active at zero, high at one.
module rhp_ref_home
  import rhp_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic         left_stop_input,
  input  wire logic         right_stop_input,
  input  wire logic         home_reference_input,
  input  wire logic         encoder_index,
  input  wire logic         step_pulse,
  input  wire logic         step_dir_up,
  output logic              irq,
  output logic              motion_hold,
  output logic              ramp_restart,
  output logic              home_region_negative
);
  // ===========================================================================
  // State
  // ===========================================================================
  typedef struct packed {
    logic [31:0]         conf;
    logic [W-1:0]        latched;
    logic [W-1:0]        home;
    logic [W-1:0]        range;
    logic [W-1:0]        target;
    logic                pos_mode;
    logic [RHP_ST_W-1:0] status;
    logic [RHP_ST_W-1:0] mask;
    logic                arm_pending;
    logic [W-1:0]        act_start;
    logic                was_at_target;
    logic [31:0]         rdata;
    logic                hold;
    logic                restart;
    logic                neg_region;
  } rhp_main_t;

  rhp_main_t st;
  rhp_main_t next_st;

  rhp_pos_if #(.W(W)) pif ();

  logic       left_act;
  logic       right_act;
  logic [3:0] src;
  logic       ref_used;
  logic       ref_high;
  logic       ref_act;
  logic       home_act;
  logic [2:0] lv;
  logic [2:0] rise;
  logic [2:0] fall;
  logic       home_evt;
  logic [W-1:0] home_val;
  logic [W:0]   mid_sum;
  logic       at_target;
  logic       zero_now;
  logic       rd_status;

  if (W < 2 || W > 32) begin : g_chk
    $error("rhp_ref_home: W must lie between 2 and 32");
  end

  // ===========================================================================
  // Switch and home levels
  // ===========================================================================
  // A polarity bit of one means the switch is high active.
  assign left_act  = left_stop_input  == st.conf[RHP_B_POL_LEFT];
  assign right_act = right_stop_input == st.conf[RHP_B_POL_RIGHT];

  assign src = st.conf[RHP_B_SRC_LO +: 4];

  // Decode which encodings use the reference input and which level is active.
  always_comb begin
    ref_used = 1'b1;
    ref_high = 1'b1;
    case (src)
      RHP_HS_HI_RISE, RHP_HS_HI_NEG, RHP_HS_HI_FALL: begin
        ref_high = 1'b1;
      end
      RHP_HS_HI_MID: begin
        ref_high = 1'b1;
      end
      RHP_HS_LO_MID: begin
        ref_high = 1'b0;
      end
      RHP_HS_LO_RISE, RHP_HS_LO_FALL: begin
        ref_high = 1'b0;
      end
      RHP_HS_LO_NEG: begin
        ref_high = 1'b0;
      end
      default: begin
        ref_used = 1'b0;
      end
    endcase
  end

  assign ref_act  = ref_used && (home_reference_input == ref_high);
  // Stop switches join the home signal only when their home bits say so.
  assign home_act = ref_act
                  | (st.conf[RHP_B_LEFT_HOME]  & left_act)
                  | (st.conf[RHP_B_RIGHT_HOME] & right_act);

  assign lv = {home_act, right_act, left_act};

  rhp_edge_det #(.W(3)) u_edges (
    .clk   (clk),
    .rst   (rst),
    .level (lv),
    .rise  (rise),
    .fall  (fall)
  );

  // ===========================================================================
  // Home event selection
  // ===========================================================================
  // Mid-range uses a one-bit wider sum so the average cannot overflow.
  assign mid_sum = {st.act_start[W-1], st.act_start}
                 + {pif.pos[W-1], pif.pos};

  always_comb begin
    home_evt = 1'b0;
    home_val = pif.pos;
    case (src)
      RHP_HS_INDEX: begin
        // A stop marked as home may still supply the event here.
        home_evt = encoder_index | rise[2];
      end
      RHP_HS_HI_FALL, RHP_HS_LO_FALL: begin
        home_evt = fall[2];
      end
      RHP_HS_HI_MID, RHP_HS_LO_MID: begin
        home_evt = fall[2];
        home_val = mid_sum[W:1];
      end
      RHP_HS_LO_RISE: begin
        home_evt = rise[2];
      end
      default: begin
        home_evt = rise[2];
      end
    endcase
  end

  // ===========================================================================
  // Arrival at target
  // ===========================================================================
  assign at_target = st.pos_mode && (pif.pos == st.target);
  // Zeroing fires once per arrival so a zero target does not retrigger.
  assign zero_now  = at_target && !st.was_at_target
                   && st.conf[RHP_B_ZERO_ARRIVE];

  assign pif.step     = step_pulse && !st.hold;
  assign pif.dir_up   = step_dir_up;
  assign pif.zero_req = zero_now;
  assign pif.wrap_en  = st.conf[RHP_B_WRAP];
  assign pif.range    = st.range;

  rhp_pos_track u_track (
    .clk (clk),
    .rst (rst),
    .pif (pif)
  );

  assign rd_status = reg_rd && (reg_addr == RHP_ADDR_STATUS);

  // ===========================================================================
  // Next-state logic
  // ===========================================================================
  // Events set status bits after the read clear, so a set is never lost.
  always_comb begin
    next_st         = st;
    next_st.restart = 1'b0;
    next_st.was_at_target = at_target;

    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        RHP_ADDR_REF_CONF: next_st.conf   = reg_wdata;
        RHP_ADDR_RANGE:    next_st.range  = reg_wdata[W-1:0];
        RHP_ADDR_TARGET:   next_st.target = reg_wdata[W-1:0];
        RHP_ADDR_MASK:     next_st.mask   = reg_wdata[RHP_ST_W-1:0];
        RHP_ADDR_CONTROL:  next_st.pos_mode = reg_wdata[RHP_B_CTRL_POS_MODE];
        default: begin
        end
      endcase
    end

    // Reading status clears it; a cleared capture event disarms tracking.
    if (rd_status) begin
      next_st.status = '0;
      if (st.status[RHP_ST_HOME_DONE] && st.arm_pending) begin
        next_st.conf[RHP_B_ARM] = 1'b0;
        next_st.arm_pending     = 1'b0;
      end
    end

    // Stop switch latching on the right and left inputs.
    if ((fall[1] && st.conf[RHP_B_LAT_INACT_R])
        || (rise[1] && st.conf[RHP_B_LAT_ACT_R])
        || (fall[0] && st.conf[RHP_B_LAT_INACT_L])
        || (rise[0] && st.conf[RHP_B_LAT_ACT_L])) begin
      next_st.latched = pif.pos;
      next_st.status[RHP_ST_STOP_LATCH] = 1'b1;
    end

    // Start of the active range is kept for the mid-range home.
    if (rise[2]) begin
      next_st.act_start = pif.pos;
    end

    // Home capture only while tracking is armed.
    if (home_evt && st.conf[RHP_B_ARM] && !st.arm_pending) begin
      next_st.home        = home_val;
      next_st.arm_pending = 1'b1;
      next_st.status[RHP_ST_HOME_DONE] = 1'b1;
    end

    // Inactive reference level marks the negative side of home.
    case (src)
      RHP_HS_HI_NEG: next_st.neg_region = !home_reference_input;
      RHP_HS_LO_NEG: next_st.neg_region = home_reference_input;
      default:       next_st.neg_region = 1'b0;
    endcase

    // Arrival: hold, or zero and let the next ramp go on at once.
    if (at_target && !st.was_at_target) begin
      next_st.status[RHP_ST_ARRIVED] = 1'b1;
    end
    if (zero_now) begin
      next_st.restart = 1'b1;
      next_st.hold    = 1'b0;
    end else begin
      next_st.hold = at_target && !st.conf[RHP_B_ZERO_ARRIVE];
    end
    if (!st.pos_mode) begin
      next_st.hold = 1'b0;
    end

    // Read data appear in the cycle after the strobe only.
    next_st.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        RHP_ADDR_REF_CONF: next_st.rdata = st.conf;
        RHP_ADDR_LATCHED:  next_st.rdata = 32'(signed'(st.latched));
        RHP_ADDR_HOME:     next_st.rdata = 32'(signed'(st.home));
        RHP_ADDR_RANGE:    next_st.rdata = 32'(st.range);
        RHP_ADDR_TARGET:   next_st.rdata = 32'(signed'(st.target));
        RHP_ADDR_ACTUAL:   next_st.rdata = 32'(signed'(pif.pos));
        RHP_ADDR_STATUS:   next_st.rdata = 32'(st.status);
        RHP_ADDR_MASK:     next_st.rdata = 32'(st.mask);
        RHP_ADDR_CONTROL:  next_st.rdata = 32'(st.pos_mode);
        default:           next_st.rdata = '0;
      endcase
    end
  end

  // ===========================================================================
  // State register
  // ===========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      st          <= '0;
      st.conf     <= RHP_REF_CONF_RST;
      st.range    <= RHP_RANGE_RST[W-1:0];
      st.target   <= RHP_WORD_RST[W-1:0];
      st.mask     <= RHP_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  assign reg_rdata            = st.rdata;
  assign irq                  = |(st.status & st.mask);
  assign motion_hold          = st.hold;
  assign ramp_restart         = st.restart;
  assign home_region_negative = st.neg_region;
endmodule

`default_nettype wire

// *** include/rhp_pkg.sv ***
// Constants shared by the reference switch and home position block.
// Assumes a word-addressed plain register port with 8-bit addresses.
`default_nettype none

package rhp_pkg;

  // ===========================================================================
  // Register addresses
  // ===========================================================================
  localparam logic [7:0] RHP_ADDR_REF_CONF = 8'h01;
  localparam logic [7:0] RHP_ADDR_LATCHED  = 8'h10;
  localparam logic [7:0] RHP_ADDR_HOME     = 8'h11;
  localparam logic [7:0] RHP_ADDR_RANGE    = 8'h12;
  localparam logic [7:0] RHP_ADDR_TARGET   = 8'h13;
  localparam logic [7:0] RHP_ADDR_ACTUAL   = 8'h14;
  localparam logic [7:0] RHP_ADDR_STATUS   = 8'h15;
  localparam logic [7:0] RHP_ADDR_MASK     = 8'h16;
  localparam logic [7:0] RHP_ADDR_CONTROL  = 8'h17;

  // ===========================================================================
  // Field positions of reference_switch_config and the control register
  // ===========================================================================
  localparam int RHP_B_POL_LEFT      = 2;
  localparam int RHP_B_POL_RIGHT     = 3;
  localparam int RHP_B_LAT_INACT_L   = 10;
  localparam int RHP_B_LAT_ACT_L     = 11;
  localparam int RHP_B_LAT_INACT_R   = 12;
  localparam int RHP_B_LAT_ACT_R     = 13;
  localparam int RHP_B_LEFT_HOME     = 14;
  localparam int RHP_B_RIGHT_HOME    = 15;
  localparam int RHP_B_SRC_LO        = 16;
  localparam int RHP_B_ARM           = 20;
  localparam int RHP_B_ZERO_ARRIVE   = 21;
  localparam int RHP_B_WRAP          = 22;
  localparam int RHP_B_CTRL_POS_MODE = 0;

  // ===========================================================================
  // Home source encodings
  // ===========================================================================
  localparam logic [3:0] RHP_HS_INDEX   = 4'h0;
  localparam logic [3:0] RHP_HS_HI_RISE = 4'h2;
  localparam logic [3:0] RHP_HS_HI_NEG  = 4'h3;
  localparam logic [3:0] RHP_HS_HI_FALL = 4'h4;
  localparam logic [3:0] RHP_HS_HI_MID  = 4'h6;
  localparam logic [3:0] RHP_HS_LO_MID  = 4'h9;
  localparam logic [3:0] RHP_HS_LO_RISE = 4'hB;
  localparam logic [3:0] RHP_HS_LO_NEG  = 4'hC;
  localparam logic [3:0] RHP_HS_LO_FALL = 4'hD;

  // ===========================================================================
  // Status bits and reset values
  // ===========================================================================
  localparam int RHP_ST_W          = 3;
  localparam int RHP_ST_HOME_DONE  = 0;
  localparam int RHP_ST_STOP_LATCH = 1;
  localparam int RHP_ST_ARRIVED    = 2;

  localparam logic [31:0] RHP_REF_CONF_RST = 32'h0000_0000;
  localparam logic [31:0] RHP_WORD_RST     = 32'h0000_0000;
  localparam logic [31:0] RHP_RANGE_RST    = 32'h0000_0000;
  localparam logic [2:0]  RHP_MASK_RST     = 3'h0;

endpackage

`default_nettype wire

// *** include/rhp_pos_if.sv ***
// Link between the control logic and the position tracker.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface rhp_pos_if #(parameter int W = 32);
  logic         step;
  logic         dir_up;
  logic         zero_req;
  logic         wrap_en;
  logic [W-1:0] range;
  logic [W-1:0] pos;

  modport ctrl (output step, output dir_up, output zero_req,
                output wrap_en, output range, input pos);
  modport trk  (input step, input dir_up, input zero_req,
                input wrap_en, input range, output pos);
endinterface

`default_nettype wire

// *** src/rhp_edge_det.sv ***
// Edge detector for a vector of levels.
// Assumes the levels are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module rhp_edge_det #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] prev;
  } rhp_edge_t;

  rhp_edge_t st;
  rhp_edge_t next_st;

  if (W < 1) begin : g_chk
    $error("rhp_edge_det: W must be at least 1");
  end

  // The previous level is kept so edges appear in the cycle of change.
  always_comb begin
    next_st.prev = level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Edges compare the present level with the one seen a cycle ago.
  assign rise = level & ~st.prev;
  assign fall = ~level & st.prev;
endmodule

`default_nettype wire

// *** src/rhp_pos_track.sv ***
// Actual position counter with optional wraparound range.
// Assumes step requests are single-cycle and range is positive.
`timescale 1ns/1ps
`default_nettype none

module rhp_pos_track (
  input wire logic clk,
  input wire logic rst,
  rhp_pos_if.trk   pif
);
  localparam int W = $bits(pif.pos);

  typedef struct packed {
    logic signed [W-1:0] pos;
  } rhp_trk_t;

  rhp_trk_t st;
  rhp_trk_t next_st;
  logic signed [W-1:0] lo;
  logic signed [W-1:0] hi;

  if (W < 2) begin : g_chk
    $error("rhp_pos_track: position width must be at least 2");
  end

  // Wrap limits are -range and range-1; zeroing beats any step.
  always_comb begin
    next_st = st;
    lo = -$signed(pif.range);
    hi = $signed(pif.range) - W'(1);
    if (pif.zero_req) begin
      next_st.pos = '0;
    end else if (pif.step) begin
      if (pif.dir_up) begin
        if (pif.wrap_en && st.pos >= hi) begin
          next_st.pos = lo;
        end else begin
          next_st.pos = st.pos + W'(1);
        end
      end else begin
        if (pif.wrap_en && st.pos <= lo) begin
          next_st.pos = hi;
        end else begin
          next_st.pos = st.pos - W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pif.pos = st.pos;
endmodule

`default_nettype wire

// *** dv/rhp_ref_home_assertions.sv ***
// Port checker for the reference switch and home position block.
// Assumes it is bound to the top module and sees every one of its ports.
`timescale 1ns/1ps
`default_nettype none

module rhp_ref_home_checker
  import rhp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        left_stop_input,
  input wire logic        right_stop_input,
  input wire logic        home_reference_input,
  input wire logic        encoder_index,
  input wire logic        step_pulse,
  input wire logic        step_dir_up,
  input wire logic        irq,
  input wire logic        motion_hold,
  input wire logic        ramp_restart,
  input wire logic        home_region_negative
);
  // ==========
  // Shadows
  // ==========
  logic [31:0] cfg;
  logic [2:0]  msk;
  logic        ctl;
  logic        exp_neg;

  // Shadows follow writes only; the arm bit may also drop inside the block.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= RHP_REF_CONF_RST;
      msk <= RHP_MASK_RST;
      ctl <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == RHP_ADDR_REF_CONF) cfg <= reg_wdata;
      if (reg_addr == RHP_ADDR_MASK) msk <= reg_wdata[2:0];
      if (reg_addr == RHP_ADDR_CONTROL) ctl <= reg_wdata[0];
    end
  end

  // The inactive home level is reported only for the two region codes.
  assign exp_neg = (cfg[19:16] == RHP_HS_HI_NEG && !home_reference_input)
                || (cfg[19:16] == RHP_HS_LO_NEG && home_reference_input);

  // ==========
  // Properties
  // ==========
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_cfg_readback: assert property (
    reg_rd && reg_addr == RHP_ADDR_REF_CONF |=>
      {reg_rdata[31:21], reg_rdata[19:0]} ==
      {$past(cfg[31:21]), $past(cfg[19:0])})
    else $error("config read differs from written value");
  a_bus_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr > RHP_ADDR_CONTROL |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_region_level: assert property (
    1'b1 |=> home_region_negative == $past(exp_neg))
    else $error("negative region flag wrong");
  a_irq_masked: assert property (irq |-> msk != 3'h0)
    else $error("interrupt with all sources masked");
  a_hold_cause: assert property (
    motion_hold |-> $past(ctl) && !$past(cfg[RHP_B_ZERO_ARRIVE]))
    else $error("hold without positioning mode or with zeroing");
  a_restart_pulse: assert property (ramp_restart |=> !ramp_restart)
    else $error("restart longer than one cycle");
  a_restart_cause: assert property (
    ramp_restart |-> $past(cfg[RHP_B_ZERO_ARRIVE]) && $past(ctl)
      && !motion_hold)
    else $error("restart without zeroing enabled");

  c_irq: cover property (irq);
  c_hold: cover property (motion_hold);
  c_restart: cover property (ramp_restart);
  c_region: cover property (home_region_negative);
endmodule

bind rhp_ref_home rhp_ref_home_checker u_chk (.*);

`default_nettype wire

// *** dv/rhp_far_side.sv ***
// Model of the switches, home sensor and encoder index at the far side.
// Assumes the bench states whether each one is active; wiring sets levels.
`timescale 1ns/1ps
`default_nettype none

module rhp_far_side (
  input  wire logic left_act,
  input  wire logic right_act,
  input  wire logic home_act,
  input  wire logic home_hi,
  input  wire logic index_act,
  output logic      left_stop_input,
  output logic      right_stop_input,
  output logic      home_reference_input,
  output logic      encoder_index
);
  // Left switch is wired low active, right one high active, both fixed.
  assign left_stop_input  = !left_act;
  assign right_stop_input = right_act;
  // The sensor level follows the active level chosen by each test.
  assign home_reference_input = home_act ~^ home_hi;
  assign encoder_index        = index_act;
endmodule

`default_nettype wire

// *** dv/rhp_ref_home_tb.sv ***
// Self-checking bench for the reference switch and home position block.
// Assumes the package register map, status layout and the far side model.
`timescale 1ns/1ps
`default_nettype none

module rhp_ref_home_tb
  import rhp_pkg::*;
;
  logic               clk, rst, reg_wr, reg_rd, step_pulse, step_dir_up;
  logic               left_act, right_act, home_act, home_hi, index_act;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, reg_rdata, home_q;
  logic               left_stop_input, right_stop_input, irq, hrn, seen;
  logic               home_reference_input, encoder_index;
  logic               motion_hold, ramp_restart;
  logic signed [31:0] pos;
  int                 failures, total_checks;

  rhp_ref_home dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .left_stop_input(left_stop_input), .right_stop_input(right_stop_input),
    .home_reference_input(home_reference_input),
    .encoder_index(encoder_index), .step_pulse(step_pulse),
    .step_dir_up(step_dir_up), .irq(irq), .motion_hold(motion_hold),
    .ramp_restart(ramp_restart), .home_region_negative(hrn));

  rhp_far_side far (
    .left_act(left_act), .right_act(right_act), .home_act(home_act),
    .home_hi(home_hi), .index_act(index_act),
    .left_stop_input(left_stop_input), .right_stop_input(right_stop_input),
    .home_reference_input(home_reference_input),
    .encoder_index(encoder_index));

  // ==========
  // Tasks
  // ==========
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic step(input int n, input logic up);
    repeat (n) begin
      @(posedge clk);
      step_pulse  <= 1'b1;
      step_dir_up <= up;
      @(posedge clk);
      step_pulse  <= 1'b0;
      pos = up ? pos + 1 : pos - 1;
    end
  endtask

  // Select 0 left stop, 1 right stop, 2 encoder index, else home sensor.
  task automatic act(input int sel, input logic v);
    @(posedge clk);
    case (sel)
      0: left_act <= v;
      1: right_act <= v;
      2: index_act <= v;
      default: home_act <= v;
    endcase
    cyc(3);
  endtask

  // Capture kind: 0 none, 1 on entering, 2 on leaving, 3 mid range.
  task automatic hcase(input logic [31:0] cf, input int sel, input int n,
                       input int cap);
    logic signed [31:0] p0;
    logic [3:0]         hs;
    hs = cf[19:16];
    @(posedge clk);
    home_hi <= !(hs inside {RHP_HS_LO_MID, RHP_HS_LO_RISE, RHP_HS_LO_NEG,
                            RHP_HS_LO_FALL});
    // A new sensor level or code can glitch the home level, so let those
    // edges pass with tracking disarmed before the armed write.
    wr(RHP_ADDR_REF_CONF, (cf & 32'hFFEF_FFFF) | 32'h0000_0008);
    cyc(2);
    wr(RHP_ADDR_REF_CONF, cf | 32'h0000_0008);
    cyc(2);
    chk("region", hs inside {RHP_HS_HI_NEG, RHP_HS_LO_NEG}, hrn);
    p0 = pos;
    act(sel, 1'b1);
    step(n, 1'b1);
    act(sel, 1'b0);
    if (cap == 1) home_q = p0;
    if (cap == 2) home_q = pos;
    if (cap == 3) home_q = (p0 + pos) >>> 1;
    rd(RHP_ADDR_HOME, home_q, "home");
    rd(RHP_ADDR_STATUS, cap != 0, "status");
    rd(RHP_ADDR_REF_CONF, (cap != 0 ? cf & 32'hFFEF_FFFF : cf) | 8,
       "conf");
  endtask

  // ==========
  // Sequence
  // ==========
  initial begin
    #2_000_000;
    failures++;
    test_done();
  end

  initial begin
    {rst, reg_wr, reg_rd, step_pulse, step_dir_up} = 5'b10000;
    {left_act, right_act, home_act, home_hi, index_act} = 5'b00010;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    pos       = 0;
    home_q    = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(8'h20, 32'hFFFF_FFFF);
    rd(RHP_ADDR_REF_CONF, 32'h0000_0000, "conf");
    rd(RHP_ADDR_STATUS, 32'h0000_0000, "status");
    rd(8'h20, 32'h0000_0000, "unmapped");
    wr(RHP_ADDR_MASK, 32'h0000_0007);
    rd(RHP_ADDR_MASK, 32'h0000_0007, "mask");
    // Right stop latching on either edge, each enable alone.
    wr(RHP_ADDR_REF_CONF, 32'h0000_2008);
    step(5, 1'b1);
    act(1, 1'b1);
    chk("irq", 1'b1, irq);
    rd(RHP_ADDR_LATCHED, pos, "latched");
    rd(RHP_ADDR_STATUS, 32'h0000_0002, "status");
    chk("irq", 1'b0, irq);
    step(2, 1'b1);
    act(1, 1'b0);
    rd(RHP_ADDR_LATCHED, 32'h0000_0005, "latched");
    wr(RHP_ADDR_MASK, 32'h0000_0000);
    wr(RHP_ADDR_REF_CONF, 32'h0000_1008);
    act(1, 1'b1);
    rd(RHP_ADDR_LATCHED, 32'h0000_0005, "latched");
    step(1, 1'b1);
    act(1, 1'b0);
    chk("irq", 1'b0, irq);
    rd(RHP_ADDR_LATCHED, pos, "latched");
    rd(RHP_ADDR_STATUS, 32'h0000_0002, "status");
    // Home sources, marks and arming.
    hcase(32'h0010_0000, 2, 1, 1);
    hcase(32'h0010_4000, 0, 1, 1);
    hcase(32'h0010_0000, 0, 1, 0);
    hcase(32'h0010_8000, 1, 1, 1);
    hcase(32'h0016_0000, 3, 4, 3);
    hcase(32'h0019_0000, 3, 3, 3);
    hcase(32'h001B_0000, 3, 2, 1);
    hcase(32'h001D_0000, 3, 2, 2);
    hcase(32'h0013_0000, 3, 1, 1);
    hcase(32'h001C_0000, 3, 1, 1);
    hcase(32'h0002_0000, 3, 1, 0);
    hcase(32'h0014_0000, 3, 2, 2);
    // Arrival with and without zeroing.
    wr(RHP_ADDR_CONTROL, 32'h0000_0001);
    wr(RHP_ADDR_TARGET, pos + 2);
    step(2, 1'b1);
    cyc(1);
    chk("hold", 1'b1, motion_hold);
    step(1, 1'b1);
    pos = pos - 1;
    rd(RHP_ADDR_ACTUAL, pos, "actual");
    wr(RHP_ADDR_TARGET, pos + 1);
    wr(RHP_ADDR_REF_CONF, 32'h0020_0008);
    step(1, 1'b1);
    seen = 1'b0;
    repeat (3) begin
      cyc(1);
      seen = seen | ramp_restart;
    end
    chk("restart", 1'b1, seen);
    rd(RHP_ADDR_ACTUAL, 32'h0000_0000, "actual");
    rd(RHP_ADDR_STATUS, 32'h0000_0004, "status");
    step(1, 1'b1);
    rd(RHP_ADDR_ACTUAL, 32'h0000_0001, "actual");
    // Wraparound inside a range of three.
    wr(RHP_ADDR_RANGE, 32'h0000_0003);
    rd(RHP_ADDR_RANGE, 32'h0000_0003, "range");
    wr(RHP_ADDR_REF_CONF, 32'h0040_0008);
    step(2, 1'b1);
    rd(RHP_ADDR_ACTUAL, 32'hFFFF_FFFD, "actual");
    step(1, 1'b0);
    rd(RHP_ADDR_ACTUAL, 32'h0000_0002, "actual");
    wr(RHP_ADDR_REF_CONF, 32'h0000_0008);
    step(1, 1'b1);
    rd(RHP_ADDR_ACTUAL, 32'h0000_0003, "actual");
    test_done();
  end
endmodule

`default_nettype wire
